// ===== pkg/sysref_cal_pkg.sv
// Shared constants and types of the SYSREF alignment calibration block.
// Assumes a 50 MHz register clock and an APB slave with word-aligned registers.
package sysref_cal_pkg;
   // Register indices; the byte address of each is four times its index.
   localparam logic [7:0] IDX_CLOCK_CTRL = 8'h27;
   localparam logic [7:0] IDX_DELAY      = 8'h28;
   localparam logic [7:0] IDX_ENABLE     = 8'h29;
   localparam logic [7:0] IDX_CONFIG     = 8'h2a;
   localparam logic [7:0] IDX_STATUS     = 8'h2b;
   localparam logic [7:0] IDX_MAP_LOW    = 8'h2c;
   localparam logic [7:0] IDX_MAP_MID    = 8'h2d;
   localparam logic [7:0] IDX_MAP_HIGH   = 8'h2e;
   // Field positions.
   localparam int DLY_FINE_LSB   = 0;
   localparam int DLY_COARSE_LSB = 8;
   localparam int DLY_INV_BIT    = 16;
   localparam int STAT_DONE_BIT  = 0;
   localparam int STAT_NOHIT_BIT = 1;
   localparam int STAT_MAPOK_BIT = 2;
   localparam int STAT_BUSY_BIT  = 3;
   localparam int STAT_RES_LSB   = 8;
   // Reset values.
   localparam logic [7:0]  DELAY_RESET  = 8'h00;
   localparam logic [3:0]  CONFIG_RESET = 4'h0;
   localparam logic [3:0]  SELECT_RESET = 4'h0;
   localparam logic [23:0] MAP_RESET    = 24'hffffff;
   // Edge positions of the map carry too little information to be trusted.
   localparam logic [23:0] MAP_EDGE_MASK = 24'h800001;
   localparam logic [1:0]  EDGES_FOR_VALID = 2'd3;
   localparam logic [7:0]  COARSE_MAX = 8'hff;
   // Settling time after each delay change.
   localparam int CLK_MHZ       = 50;
   localparam int SETTLE_NS     = 200;
   localparam int SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   typedef enum logic [2:0] {S_IDLE, S_SETTLE, S_WAIT_EDGE, S_SAMPLE, S_FINISH} state_t;
endpackage

// ===== pkg/position_map_if.sv
// Carries SYSREF edge events and the sampling position map between modules.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface position_map_if;
   logic        sysrefEdge;
   logic [23:0] map;
   logic        mapValid;
   modport detector (output sysrefEdge, output map, output mapValid);
   modport consumer (input sysrefEdge, input map, input mapValid);
endinterface

// ===== verilog/sref_position_detector.sv
// SYSREF synchroniser, edge counter and sampling position map capture.
// Assumes the raw position flags and SYSREF arrive asynchronously on pins.
`timescale 1ns/10ps
module sref_position_detector (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        sysrefIn,
   input  wire logic [23:0] positionRawIn,
   position_map_if.detector pm
);
   logic [2:0]  sysSync_reg;
   logic [23:0] rawS1_reg, rawS2_reg, rawS3_reg;
   logic        level_reg, level_next;
   logic [23:0] raw_reg, raw_next;
   logic [23:0] map_reg, map_next;
   logic [1:0]  cnt_reg, cnt_next;
   logic        valid_reg, valid_next;
   logic        edge_reg, edge_next;

   // Three-stage synchronisers; only the second and third stages are compared.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sysSync_reg <= 3'h0;
         rawS1_reg   <= 24'h000000;
         rawS2_reg   <= 24'h000000;
         rawS3_reg   <= 24'h000000;
      end else begin
         sysSync_reg <= {sysSync_reg[1:0], sysrefIn};
         rawS1_reg   <= positionRawIn;
         rawS2_reg   <= rawS1_reg;
         rawS3_reg   <= rawS2_reg;
      end
   end

   // A new level counts only once two stages agree, which filters metastable glitches.
   always_comb begin
      level_next = (sysSync_reg[1] == sysSync_reg[2]) ? sysSync_reg[2] : level_reg;
      raw_next   = (rawS2_reg == rawS3_reg) ? rawS3_reg : raw_reg;
      edge_next  = level_next && !level_reg;
      map_next   = map_reg;
      cnt_next   = cnt_reg;
      if (edge_next) begin
         map_next = raw_reg | sysref_cal_pkg::MAP_EDGE_MASK; // RULE14 RULE15
         if (cnt_reg != sysref_cal_pkg::EDGES_FOR_VALID) begin
            cnt_next = cnt_reg + 2'd1;
         end
      end
      valid_next = (cnt_next == sysref_cal_pkg::EDGES_FOR_VALID); // RULE13
   end

   // State registers of the detector.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         level_reg <= 1'b0;
         raw_reg   <= 24'h000000;
         map_reg   <= sysref_cal_pkg::MAP_RESET;
         cnt_reg   <= 2'd0;
         valid_reg <= 1'b0;
         edge_reg  <= 1'b0;
      end else begin
         level_reg <= level_next;
         raw_reg   <= raw_next;
         map_reg   <= map_next;
         cnt_reg   <= cnt_next;
         valid_reg <= valid_next;
         edge_reg  <= edge_next;
      end
   end

   assign pm.sysrefEdge = edge_reg;
   assign pm.map        = map_reg;
   assign pm.mapValid   = valid_reg;

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   a_map_edge_bits: assert property (map_reg[0] && map_reg[23]) // RULE15
      else $error("Map edge positions not flagged.");
   a_map_valid_count: assert property (valid_reg |-> cnt_reg == sysref_cal_pkg::EDGES_FOR_VALID) // RULE13
      else $error("Map valid before three SYSREF edges.");
   a_map_capture: assert property ($rose(level_reg)
         |-> map_reg == ($past(raw_reg) | sysref_cal_pkg::MAP_EDGE_MASK)) // RULE14
      else $error("Map not captured from flags at SYSREF edge.");
endmodule

// ===== verilog/sysref_auto_calibration.sv
// Automatic SYSREF alignment calibration with APB register access.
// Assumes an analog phase comparator flag and raw position flags on pins.
//
// How it works
// [RULE1] Software starts only with a stable clock and normal configuration.
// [RULE2] The clock source keeps SYSREF periodic throughout the search.
// [RULE3] Software writes the configuration before setting the enable bit.
// [RULE4] Enabled search steps delay until clock falling edge meets SYSREF rising edge.
// [RULE5] A done flag in status is set when the search ends.
// [RULE6] The found delay is readable in a status result field.
// [RULE7] The found delay stays applied until software overrides it.
// [RULE8] Software may disable calibration and write delays manually.
// [RULE9] Converter calibration must be off while the alignment runs.
// [RULE10] Software keeps the position select at zero during calibration.
// [RULE11] Both polarities are searched and the smallest coarse delay wins.
// [RULE12] The receiver picks a proper elastic buffer release point.
// [RULE13] The position map is valid only after three SYSREF rising edges.
// [RULE14] A map bit reads one when its position risks setup or hold.
// [RULE15] Map bits zero and twenty-three always read one.
// [RULE16] The select field reaches only map positions zero to fifteen.
// [RULE17] Starting a new search clears the done flag.
// [RULE18] The map reads as three bytes, smallest delay at lowest address.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module sysref_auto_calibration (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        sysrefIn,
   input  wire logic [23:0] positionRawIn,
   input  wire logic        edgeAlignedIn,
   output logic             apertureInvert,
   output logic [7:0]       apertureCoarse,
   output logic [7:0]       apertureFine,
   output logic [3:0]       samplePositionSelect
);
   localparam logic [7:0] SETTLE_LAST = 8'(sysref_cal_pkg::SETTLE_CYCLES - 1);

   position_map_if pm ();

   sref_position_detector u_detector (
      .clk           (clk),
      .resetn        (resetn),
      .sysrefIn      (sysrefIn),
      .positionRawIn (positionRawIn),
      .pm            (pm.detector)
   );

   //**********************************************************************
   // APB slave
   //**********************************************************************
   logic        pready_reg, pready_next;
   logic [31:0] prdata_reg, prdata_next;
   logic        pslverr_reg, pslverr_next;
   logic        addrOk;
   logic [7:0]  index;
   logic        apbWrite;
   logic        start;
   logic        delayWrite;

   logic                   enable_reg, enable_next;
   logic [3:0]             config_reg, config_next;
   logic [3:0]             select_reg, select_next;
   logic                   done_reg, done_next;
   logic                   found_reg, found_next;
   logic                   inv_reg, inv_next;
   logic [7:0]             coarse_reg, coarse_next;
   logic [7:0]             fine_reg, fine_next;
   sysref_cal_pkg::state_t state_reg, state_next;
   logic                   pol_reg, pol_next;
   logic [7:0]             stepCoarse_reg, stepCoarse_next;
   logic [7:0]             settle_reg, settle_next;
   logic [3:0]             edges_reg, edges_next;
   logic                   bestInv_reg, bestInv_next;
   logic [7:0]             bestCoarse_reg, bestCoarse_next;
   logic [2:0]             alignSync_reg;
   logic                   aligned_reg, aligned_next;

   // Word index decode; the upper address bits and the byte offset must be zero.
   assign index      = paddr[9:2];
   assign addrOk     = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
   assign apbWrite   = psel && penable && pready_reg && pwrite && addrOk;
   assign start      = apbWrite && (index == sysref_cal_pkg::IDX_ENABLE) && pwdata[0]
                       && !enable_reg;
   // Manual delay writes are ignored while a search owns the delay line.
   assign delayWrite = apbWrite && (index == sysref_cal_pkg::IDX_DELAY)
                       && (state_reg == sysref_cal_pkg::S_IDLE);

   // Read data is prepared in the setup cycle so every access answers in one wait-free cycle.
   always_comb begin
      pready_next  = psel && !penable;
      prdata_next  = prdata_reg;
      pslverr_next = 1'b0;
      if (psel && !penable) begin
         prdata_next = 32'h00000000;
         if (!addrOk) begin
            pslverr_next = 1'b1;
         end else begin
            case (index)
               sysref_cal_pkg::IDX_CLOCK_CTRL: prdata_next[3:0] = select_reg; // RULE16
               sysref_cal_pkg::IDX_DELAY: begin
                  prdata_next[sysref_cal_pkg::DLY_FINE_LSB +: 8]   = fine_reg;
                  prdata_next[sysref_cal_pkg::DLY_COARSE_LSB +: 8] = coarse_reg;
                  prdata_next[sysref_cal_pkg::DLY_INV_BIT]         = inv_reg;
               end
               sysref_cal_pkg::IDX_ENABLE: prdata_next[0] = enable_reg;
               sysref_cal_pkg::IDX_CONFIG: prdata_next[3:0] = config_reg;
               sysref_cal_pkg::IDX_STATUS: begin
                  prdata_next[sysref_cal_pkg::STAT_DONE_BIT]  = done_reg; // RULE5
                  prdata_next[sysref_cal_pkg::STAT_NOHIT_BIT] = done_reg && !found_reg;
                  prdata_next[sysref_cal_pkg::STAT_MAPOK_BIT] = pm.mapValid; // RULE13
                  prdata_next[sysref_cal_pkg::STAT_BUSY_BIT]  =
                     (state_reg != sysref_cal_pkg::S_IDLE);
                  prdata_next[sysref_cal_pkg::STAT_RES_LSB +: 9] =
                     {bestInv_reg, bestCoarse_reg}; // RULE6
               end
               sysref_cal_pkg::IDX_MAP_LOW:  prdata_next[7:0] = pm.map[7:0]; // RULE18
               sysref_cal_pkg::IDX_MAP_MID:  prdata_next[7:0] = pm.map[15:8]; // RULE18
               sysref_cal_pkg::IDX_MAP_HIGH: prdata_next[7:0] = pm.map[23:16]; // RULE18
               default: pslverr_next = 1'b1;
            endcase
         end
      end
   end

   // Bus answer registers.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h00000000;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg  <= pready_next;
         prdata_reg  <= prdata_next;
         pslverr_reg <= pslverr_next;
      end
   end

   //**********************************************************************
   // Alignment search
   //**********************************************************************

   // Phase comparator flag from the analog clock path, three-stage synchronised.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         alignSync_reg <= 3'h0;
      end else begin
         alignSync_reg <= {alignSync_reg[1:0], edgeAlignedIn};
      end
   end

   // Search sequencer and software-visible control state.
   always_comb begin
      aligned_next    = (alignSync_reg[1] == alignSync_reg[2]) ? alignSync_reg[2] : aligned_reg;
      enable_next     = enable_reg;
      config_next     = config_reg;
      select_next     = select_reg;
      done_next       = done_reg;
      found_next      = found_reg;
      inv_next        = inv_reg;
      coarse_next     = coarse_reg;
      fine_next       = fine_reg;
      state_next      = state_reg;
      pol_next        = pol_reg;
      stepCoarse_next = stepCoarse_reg;
      settle_next     = settle_reg;
      edges_next      = edges_reg;
      bestInv_next    = bestInv_reg;
      bestCoarse_next = bestCoarse_reg;
      if (apbWrite && index == sysref_cal_pkg::IDX_ENABLE) begin
         enable_next = pwdata[0];
      end
      if (apbWrite && index == sysref_cal_pkg::IDX_CONFIG) begin
         config_next = pwdata[3:0];
      end
      if (apbWrite && index == sysref_cal_pkg::IDX_CLOCK_CTRL) begin
         select_next = pwdata[3:0]; // RULE16
      end
      // A manual write replaces the calibrated delay; otherwise it is held until a new search starts.
      if (delayWrite) begin
         fine_next   = pwdata[sysref_cal_pkg::DLY_FINE_LSB +: 8];
         coarse_next = pwdata[sysref_cal_pkg::DLY_COARSE_LSB +: 8];
         inv_next    = pwdata[sysref_cal_pkg::DLY_INV_BIT]; // RULE7
      end
      case (state_reg)
         sysref_cal_pkg::S_IDLE: begin
            if (start) begin
               done_next       = 1'b0; // RULE17
               found_next      = 1'b0;
               pol_next        = 1'b0;
               stepCoarse_next = 8'h00;
               inv_next        = 1'b0;
               coarse_next     = 8'h00;
               settle_next     = 8'h00;
               state_next      = sysref_cal_pkg::S_SETTLE;
            end
         end
         sysref_cal_pkg::S_SETTLE: begin
            settle_next = settle_reg + 8'h01;
            if (settle_reg == SETTLE_LAST) begin
               edges_next = 4'h0;
               state_next = sysref_cal_pkg::S_WAIT_EDGE;
            end
         end
         sysref_cal_pkg::S_WAIT_EDGE: begin
            // Relies on a periodic SYSREF; a stopped SYSREF stalls here until disabled.
            if (pm.sysrefEdge) begin // RULE2
               if (edges_reg == config_reg) begin
                  state_next = sysref_cal_pkg::S_SAMPLE;
               end else begin
                  edges_next = edges_reg + 4'h1;
               end
            end
         end
         sysref_cal_pkg::S_SAMPLE: begin
            if (aligned_reg && (!found_reg || stepCoarse_reg < bestCoarse_reg)) begin
               found_next      = 1'b1; // RULE11
               bestInv_next    = pol_reg;
               bestCoarse_next = stepCoarse_reg;
            end
            settle_next = 8'h00;
            state_next  = sysref_cal_pkg::S_SETTLE;
            if (aligned_reg || stepCoarse_reg == sysref_cal_pkg::COARSE_MAX) begin
               if (pol_reg) begin
                  state_next = sysref_cal_pkg::S_FINISH;
               end else begin
                  pol_next        = 1'b1; // RULE11
                  stepCoarse_next = 8'h00;
               end
            end else begin
               stepCoarse_next = stepCoarse_reg + 8'h01; // RULE4
            end
            inv_next    = pol_next;
            coarse_next = stepCoarse_next;
         end
         sysref_cal_pkg::S_FINISH: begin
            done_next  = 1'b1; // RULE5
            state_next = sysref_cal_pkg::S_IDLE;
            if (found_reg) begin
               inv_next    = bestInv_reg; // RULE6 RULE7
               coarse_next = bestCoarse_reg;
            end
         end
         default: state_next = sysref_cal_pkg::S_IDLE;
      endcase
      // Clearing the enable aborts a running search without reporting completion.
      if (!enable_reg && state_reg != sysref_cal_pkg::S_IDLE) begin
         state_next = sysref_cal_pkg::S_IDLE;
         done_next  = 1'b0;
      end
   end

   // Search and control registers.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         aligned_reg    <= 1'b0;
         enable_reg     <= 1'b0;
         config_reg     <= sysref_cal_pkg::CONFIG_RESET;
         select_reg     <= sysref_cal_pkg::SELECT_RESET;
         done_reg       <= 1'b0;
         found_reg      <= 1'b0;
         inv_reg        <= 1'b0;
         coarse_reg     <= sysref_cal_pkg::DELAY_RESET;
         fine_reg       <= sysref_cal_pkg::DELAY_RESET;
         state_reg      <= sysref_cal_pkg::S_IDLE;
         pol_reg        <= 1'b0;
         stepCoarse_reg <= 8'h00;
         settle_reg     <= 8'h00;
         edges_reg      <= 4'h0;
         bestInv_reg    <= 1'b0;
         bestCoarse_reg <= 8'h00;
      end else begin
         aligned_reg    <= aligned_next;
         enable_reg     <= enable_next;
         config_reg     <= config_next;
         select_reg     <= select_next;
         done_reg       <= done_next;
         found_reg      <= found_next;
         inv_reg        <= inv_next;
         coarse_reg     <= coarse_next;
         fine_reg       <= fine_next;
         state_reg      <= state_next;
         pol_reg        <= pol_next;
         stepCoarse_reg <= stepCoarse_next;
         settle_reg     <= settle_next;
         edges_reg      <= edges_next;
         bestInv_reg    <= bestInv_next;
         bestCoarse_reg <= bestCoarse_next;
      end
   end

   assign pready               = pready_reg;
   assign prdata               = prdata_reg;
   assign pslverr              = pslverr_reg;
   assign apertureInvert       = inv_reg;
   assign apertureCoarse       = coarse_reg;
   assign apertureFine         = fine_reg;
   assign samplePositionSelect = select_reg;

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   a_start_clears_done: assert property (start |=> !done_reg) // RULE17
      else $error("Done flag survived a new start.");
   a_finish_sets_done: assert property ((state_reg == sysref_cal_pkg::S_FINISH && enable_reg)
         |=> done_reg && state_reg == sysref_cal_pkg::S_IDLE) // RULE5
      else $error("Done flag not set after search.");
   a_result_applied: assert property (($rose(done_reg) && found_reg)
         |-> coarse_reg == bestCoarse_reg && inv_reg == bestInv_reg) // RULE6
      else $error("Found delay not applied at completion.");
   a_delay_kept: assert property ((state_reg == sysref_cal_pkg::S_IDLE && !delayWrite && !start)
         |=> $stable(coarse_reg) && $stable(inv_reg) && $stable(fine_reg)) // RULE7
      else $error("Applied delay changed without a write.");
   a_step_forward: assert property ((state_reg == sysref_cal_pkg::S_SAMPLE && enable_reg // RULE4
         && !aligned_reg && stepCoarse_reg != sysref_cal_pkg::COARSE_MAX)
         |=> coarse_reg == $past(stepCoarse_reg) + 8'h01 && state_reg == sysref_cal_pkg::S_SETTLE)
      else $error("Search did not step the coarse delay.");
   a_smallest_kept: assert property ((state_reg == sysref_cal_pkg::S_SAMPLE && found_reg
         && stepCoarse_reg >= bestCoarse_reg) |=> $stable(bestCoarse_reg)) // RULE11
      else $error("A larger coarse delay replaced a smaller one.");
   a_both_polarities: assert property (state_reg == sysref_cal_pkg::S_FINISH |-> pol_reg) // RULE11
      else $error("Search finished without the inverted polarity.");
   a_map_byte_order: assert property ((psel && !penable && !pwrite && addrOk
         && index == sysref_cal_pkg::IDX_MAP_LOW)
         |=> pready_reg && prdata_reg == {24'h000000, $past(pm.map[7:0])}) // RULE18
      else $error("Low map byte not read at lowest address.");
endmodule

// ===== bench/sysref_source.sv
// Model of the clock source that feeds the calibration block.
// Assumes the bench supplies the device clock and picks the aligned delays.
`timescale 1ns/10ps
module sysref_source #(
   parameter int PERIOD = 16
) (
   input  wire logic       clk,
   input  wire logic       apertureInvert,
   input  wire logic [7:0] apertureCoarse,
   input  wire logic [7:0] alignCoarse0,
   input  wire logic [7:0] alignCoarse1,
   output logic            sysrefIn,
   output logic            edgeAlignedIn
);
   int cnt = 0;
   // SYSREF never pauses, so every search step is sure to see its edges.
   always @(posedge clk) begin
      cnt <= (cnt + 1) % PERIOD;
      sysrefIn <= (cnt < PERIOD / 2);
   end
   // Each polarity aligns at exactly one coarse value, so a wrong pick shows.
   assign edgeAlignedIn = apertureCoarse == (apertureInvert ? alignCoarse1 : alignCoarse0);
endmodule

// ===== bench/sysref_auto_calibration_tb.sv
// Self-checking bench of the SYSREF alignment calibration block.
// Assumes the clock source model drives SYSREF and the comparator flag.
`timescale 1ns/10ps
module sysref_auto_calibration_tb;
   typedef struct {logic c; logic [32:0] m; logic [32:0] e;} note_t;
   logic        clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdv;
   logic        pready, pslverr, sysrefIn, edgeAlignedIn, apertureInvert;
   logic [23:0] raw = 24'h0, mp;
   logic [7:0]  apertureCoarse, apertureFine, tgt0 = 8'h0, tgt1 = 8'h0;
   logic [3:0]  samplePositionSelect;
   int          num_errors = 0, cmp_count = 0, i;
   note_t       q[$], n;

   // The device clock runs steadily from time zero on.
   always #10 clk = ~clk;

   sysref_auto_calibration uut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .sysrefIn(sysrefIn), .positionRawIn(raw),
      .edgeAlignedIn(edgeAlignedIn), .apertureInvert(apertureInvert),
      .apertureCoarse(apertureCoarse), .apertureFine(apertureFine),
      .samplePositionSelect(samplePositionSelect));
   sysref_source src (.clk(clk), .apertureInvert(apertureInvert),
      .apertureCoarse(apertureCoarse), .alignCoarse0(tgt0), .alignCoarse1(tgt1),
      .sysrefIn(sysrefIn), .edgeAlignedIn(edgeAlignedIn));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(string name, logic [32:0] seen, logic [32:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One APB transfer; a read also leaves a note for the monitor.
   task automatic xfer(logic w, logic [7:0] idx, logic [31:0] d, logic c,
                       logic [32:0] m, logic [32:0] e);
      int k;
      if (!w) q.push_back('{c, m, e});
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (pready !== 1'b1) begin
         num_errors++;
         test_done();
      end
      rdv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(logic [7:0] idx, logic [31:0] d);
      xfer(1'b1, idx, d, 1'b0, 33'h0, 33'h0);
   endtask
   task automatic rd(logic [7:0] idx, logic [32:0] m, logic [32:0] e);
      xfer(1'b0, idx, 32'h0, 1'b1, m, e);
   endtask
   // Polls a status bit with a bounded count; running out ends the run.
   task automatic poll(int b);
      for (int k = 0; k < 3000; k++) begin
         xfer(1'b0, sysref_cal_pkg::IDX_STATUS, 32'h0, 1'b0, 33'h0, 33'h0);
         if (rdv[b] === 1'b1) return;
      end
      num_errors++;
      test_done();
   endtask

   // Read results are compared in order as each access phase completes.
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
         n = q.pop_front();
         if (n.c) check("apb read", {pslverr, prdata} & n.m, n.e);
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      i = $urandom(32'h503eee32);
      raw <= 24'($urandom);
      tgt0 <= 8'd3 + 8'($urandom % 4);
      tgt1 <= 8'($urandom % 3);
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      mp = raw | sysref_cal_pkg::MAP_EDGE_MASK;
      poll(sysref_cal_pkg::STAT_MAPOK_BIT);
      for (i = 0; i < 3; i++)
         rd(sysref_cal_pkg::IDX_MAP_LOW + 8'(i), 33'hff, {25'b0, mp[8*i +: 8]});
      $display("position map test done");
      wr(sysref_cal_pkg::IDX_CLOCK_CTRL, 32'h5);
      rd(sysref_cal_pkg::IDX_CLOCK_CTRL, 33'hf, 33'h5);
      check("select", {29'b0, samplePositionSelect}, 33'h5);
      wr(sysref_cal_pkg::IDX_CLOCK_CTRL, 32'h0);
      // No converter calibration runs in this bench, and no receiver buffer is modelled.
      rd(8'h30, 33'h1_0000_0000, 33'h1_0000_0000);
      $display("select and unmapped test done");
      wr(sysref_cal_pkg::IDX_CONFIG, 32'h1);
      wr(sysref_cal_pkg::IDX_ENABLE, 32'h1);
      poll(sysref_cal_pkg::STAT_DONE_BIT);
      rd(sysref_cal_pkg::IDX_STATUS, 33'h1ff0b, {16'b0, 1'b1, tgt1, 8'h01});
      rd(sysref_cal_pkg::IDX_DELAY, 33'h1ffff, {16'b0, 1'b1, tgt1, 8'h00});
      check("delay", {16'b0, apertureInvert, apertureCoarse, apertureFine},
            {16'b0, 1'b1, tgt1, 8'h00});
      $display("search test done");
      wr(sysref_cal_pkg::IDX_ENABLE, 32'h0);
      wr(sysref_cal_pkg::IDX_ENABLE, 32'h1);
      rd(sysref_cal_pkg::IDX_STATUS, 33'h9, 33'h8);
      wr(sysref_cal_pkg::IDX_ENABLE, 32'h0);
      rd(sysref_cal_pkg::IDX_STATUS, 33'h9, 33'h0);
      wr(sysref_cal_pkg::IDX_DELAY, 32'h0001_2a37);
      rd(sysref_cal_pkg::IDX_DELAY, 33'h1ffff, 33'h1_2a37);
      check("manual", {16'b0, apertureInvert, apertureCoarse, apertureFine}, 33'h1_2a37);
      $display("restart and override test done");
      test_done();
   end
endmodule
